// file: core/plc_core.sv
// top of the logic cell back end: registers, gates, function, polarity, events
`timescale 1ns/100ps
`default_nettype none
module plc_core
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // register port
    input wire plc_pkg::plc_bus_t bus_req,
    output logic [7:0] bus_rdata,
    // data from the input selection stage
    input wire logic [3:0] data_true,
    // selects of gates 1, 2 and 4 from neighbouring registers
    input wire plc_pkg::plc_sel_t g1_sel,
    input wire plc_pkg::plc_sel_t g2_sel,
    input wire plc_pkg::plc_sel_t g4_sel,
    // cell result to peripherals and feedback
    output logic cell_out,
    output logic input_mix_en,
    output logic irq_set,
    // output pin
    output logic pin_out,
    output logic pin_oe_n
);

    plc_pkg::plc_core_st_t st_reg;
    plc_pkg::plc_core_st_t st_next;
    plc_pkg::plc_sel_t g3_sel_reg;
    plc_pkg::plc_sel_t sel_all [4];
    plc_pkg::plc_gates_t gates;
    logic func_raw;
    logic wr_ctl;
    logic wr_g3;
    logic wr_pol;

    // ****************************************************************
    // address decode
    // ****************************************************************
    always_comb
    begin
        wr_ctl = 1'b0;
        wr_g3 = 1'b0;
        wr_pol = 1'b0;
        if (bus_req.wr && bus_req.addr == plc_pkg::OFS_CONTROL)
            wr_ctl = 1'b1;
        else if (bus_req.wr && bus_req.addr == plc_pkg::OFS_G3_SELECT)
            wr_g3 = 1'b1;
        else if (bus_req.wr && bus_req.addr == plc_pkg::OFS_POLARITY)
            wr_pol = 1'b1;
    end

    // ****************************************************************
    // gate 3 select, no reset: keeps content across resets
    // ****************************************************************
    always_ff @(posedge core_clk)
    begin
        if (wr_g3)
            g3_sel_reg <= bus_req.wdata;
    end

    // ****************************************************************
    // data gates and logic function
    // ****************************************************************
    assign sel_all[0] = g1_sel;
    assign sel_all[1] = g2_sel;
    assign sel_all[2] = g3_sel_reg;
    assign sel_all[3] = g4_sel;

    genvar g;
    generate
        for (g = 0; g < 4; g++)
        begin : g_gate
            plc_gate u_gate
            (
                .sel(sel_all[g]),
                .invert(st_reg.gate_inv[g]),
                .data(data_true),
                .gate_out(gates[g])
            );
        end
    endgenerate

    plc_func u_func
    (
        .core_clk(core_clk),
        .rstn(rstn),
        .enable(st_reg.ctl.en),
        .func(st_reg.ctl.func),
        .gates(gates),
        .func_out(func_raw)
    );

    // ****************************************************************
    // next state: registers, output stage, edge events, read data
    // ****************************************************************
    always_comb
    begin
        st_next = st_reg;
        // control writes, output level bit is not writable
        if (wr_ctl)
        begin
            st_next.ctl.en = bus_req.wdata[plc_pkg::BIT_ENABLE];
            st_next.ctl.oe = bus_req.wdata[plc_pkg::BIT_PIN_OE];
            st_next.ctl.rise = bus_req.wdata[plc_pkg::BIT_RISE_EN];
            st_next.ctl.fall = bus_req.wdata[plc_pkg::BIT_FALL_EN];
            st_next.ctl.func = plc_pkg::plc_func_t'(
                bus_req.wdata[plc_pkg::BIT_FUNC_MSB:plc_pkg::BIT_FUNC_LSB]);
        end
        // polarity writes
        if (wr_pol)
        begin
            st_next.out_inv = bus_req.wdata[plc_pkg::BIT_OUT_INV];
            st_next.gate_inv = bus_req.wdata[plc_pkg::BIT_GATE_INV_MSB:0];
        end
        // output stage, low while the cell is off
        st_next.out = st_reg.ctl.en & (func_raw ^ st_reg.out_inv);
        // edge events, a polarity flip counts as an edge
        st_next.pulse = (st_next.out & ~st_reg.out & st_reg.ctl.rise)
            | (~st_next.out & st_reg.out & st_reg.ctl.fall);
        // read data, valid only in the cycle after the strobe
        st_next.rdata = 8'h00;
        if (bus_req.rd && bus_req.addr == plc_pkg::OFS_CONTROL)
            st_next.rdata = {st_reg.ctl.en, st_reg.ctl.oe, st_reg.out,
                st_reg.ctl.rise, st_reg.ctl.fall, st_reg.ctl.func};
        else if (bus_req.rd && bus_req.addr == plc_pkg::OFS_G3_SELECT)
            st_next.rdata = g3_sel_reg;
        else if (bus_req.rd && bus_req.addr == plc_pkg::OFS_POLARITY)
            st_next.rdata = {st_reg.out_inv, 3'h0, st_reg.gate_inv};
    end

    // state register
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            st_reg <= plc_pkg::CORE_RST;
        else
            st_reg <= st_next;
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign cell_out = st_reg.out;
    assign input_mix_en = st_reg.ctl.en;
    assign irq_set = st_reg.pulse;
    assign bus_rdata = st_reg.rdata;
    // pin is driven with the cell result while enabled, low enable drives
    assign pin_out = st_reg.out;
    assign pin_oe_n = ~st_reg.ctl.oe;

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rstn);

    // off cell holds its output low
    chk_disable_quiet: assert property (
        !st_reg.ctl.en ##1 !st_reg.ctl.en |-> !cell_out)
        else $error("disabled cell output not low");

    // enabled output equals function result through polarity
    chk_invert_path: assert property (
        st_reg.ctl.en |=> cell_out == ($past(func_raw) ^ $past(st_reg.out_inv)))
        else $error("output polarity path wrong");

    // polarity flip with steady function toggles the output
    chk_pol_change: assert property (
        st_reg.ctl.en && $past(st_reg.ctl.en) && $changed(st_reg.out_inv)
        && $stable(func_raw) |=> $changed(cell_out))
        else $error("polarity change did not toggle output");

    // enabled rising edge raises the event in the same cycle
    chk_rise_flag: assert property (
        $rose(cell_out) && $past(st_reg.ctl.rise) |-> irq_set)
        else $error("rising edge event missing");

    // enabled falling edge raises the event in the same cycle
    chk_fall_flag: assert property (
        $fell(cell_out) && $past(st_reg.ctl.fall) |-> irq_set)
        else $error("falling edge event missing");

    // no event without an enabled edge
    chk_no_stray_flag: assert property (
        irq_set |-> ($rose(cell_out) && $past(st_reg.ctl.rise))
        || ($fell(cell_out) && $past(st_reg.ctl.fall)))
        else $error("event without enabled edge");

    // pin enable follows the written bit one cycle later
    chk_pin_drive: assert property (
        wr_ctl |=> pin_oe_n == !$past(bus_req.wdata[plc_pkg::BIT_PIN_OE]))
        else $error("pin output enable wrong");

    // output level bit reads the live output
    chk_out_bit_ro: assert property (
        bus_req.rd && bus_req.addr == plc_pkg::OFS_CONTROL
        |=> bus_rdata[plc_pkg::BIT_OUT_LEVEL] == $past(cell_out))
        else $error("output level bit wrong");

    // function field takes the written code
    chk_mode_write: assert property (
        wr_ctl |=> st_reg.ctl.func == $past(bus_req.wdata[2:0]))
        else $error("function select not stored");

    // gate 3 select stores written data
    chk_g3_write: assert property (
        wr_g3 |=> g3_sel_reg == $past(bus_req.wdata))
        else $error("gate 3 select not stored");

    // empty gate 3 gives its polarity level
    chk_empty_gate: assert property (
        g3_sel_reg == 8'h00 |-> gates[2] == ~st_reg.gate_inv[2])
        else $error("empty gate level wrong");

    // four-input and function
    chk_and4: assert property (
        st_reg.ctl.func == plc_pkg::FN_AND4 |-> func_raw == &gates)
        else $error("and function wrong");

    // read data back to zero after its cycle
    chk_rdata_idle: assert property (
        !bus_req.rd |=> bus_rdata == 8'h00)
        else $error("read data not cleared");

    // polarity register reads back
    chk_pol_read: assert property (
        bus_req.rd && bus_req.addr == plc_pkg::OFS_POLARITY
        |=> bus_rdata == {$past(st_reg.out_inv), 3'h0, $past(st_reg.gate_inv)})
        else $error("polarity read wrong");

    // gate 3 select reads back
    chk_g3_read: assert property (
        bus_req.rd && bus_req.addr == plc_pkg::OFS_G3_SELECT
        |=> bus_rdata == $past(g3_sel_reg))
        else $error("gate 3 read wrong");

    // enable bit reads back
    chk_ctl_read: assert property (
        bus_req.rd && bus_req.addr == plc_pkg::OFS_CONTROL
        |=> bus_rdata[plc_pkg::BIT_ENABLE] == $past(st_reg.ctl.en))
        else $error("enable read wrong");

    // input mixing follows enable
    chk_mix_enable: assert property (
        wr_ctl |=> input_mix_en == $past(bus_req.wdata[plc_pkg::BIT_ENABLE]))
        else $error("mixing enable wrong");

    // rise enable stored
    chk_rise_store: assert property (
        wr_ctl |=> st_reg.ctl.rise == $past(bus_req.wdata[plc_pkg::BIT_RISE_EN]))
        else $error("rise enable not stored");

    // fall enable stored
    chk_fall_store: assert property (
        wr_ctl |=> st_reg.ctl.fall == $past(bus_req.wdata[plc_pkg::BIT_FALL_EN]))
        else $error("fall enable not stored");

    // output invert stored
    chk_inv_store: assert property (
        wr_pol |=> st_reg.out_inv == $past(bus_req.wdata[plc_pkg::BIT_OUT_INV]))
        else $error("output invert not stored");

    // gate inverts stored
    chk_gate_inv_store: assert property (
        wr_pol |=> st_reg.gate_inv == $past(bus_req.wdata[plc_pkg::BIT_GATE_INV_MSB:0]))
        else $error("gate invert not stored");

    // no event with both edges off
    chk_no_event_off: assert property (
        !$past(st_reg.ctl.rise) && !$past(st_reg.ctl.fall) |-> !irq_set)
        else $error("event with edges off");

    // or-xor function
    chk_or_xor: assert property (
        st_reg.ctl.en && st_reg.ctl.func == plc_pkg::FN_OR_XOR
        |-> func_raw == ((gates[0] | gates[1]) ^ (gates[2] | gates[3])))
        else $error("or-xor wrong");

    // and-or function
    chk_and_or: assert property (
        st_reg.ctl.en && st_reg.ctl.func == plc_pkg::FN_AND_OR
        |-> func_raw == ((gates[0] & gates[1]) | (gates[2] & gates[3])))
        else $error("and-or wrong");

    // true and negated data 1 close gate 3
    chk_full_gate: assert property (
        g3_sel_reg[1:0] == 2'b11 |-> gates[2] == st_reg.gate_inv[2])
        else $error("closed gate level wrong");

    // data 1 true alone passes gate 3
    chk_true_gate: assert property (
        g3_sel_reg == 8'h02 |-> gates[2] == (data_true[0] ^ st_reg.gate_inv[2]))
        else $error("gate 3 true data wrong");

    // s-r latch clears on reset alone
    chk_sr_reset: assert property (
        st_reg.ctl.en && st_reg.ctl.func == plc_pkg::FN_SR_LATCH && !gates[0] && !gates[1]
        && (gates[2] || gates[3]) ##1 st_reg.ctl.func == plc_pkg::FN_SR_LATCH |-> !func_raw)
        else $error("s-r latch did not clear");

    cov_rise_event: cover property ($rose(cell_out) && irq_set);
    cov_fall_event: cover property ($fell(cell_out) && irq_set);
    cov_pol_flip: cover property (st_reg.ctl.en && $changed(st_reg.out_inv));
    cov_jk_mode: cover property (st_reg.ctl.en && st_reg.ctl.func == plc_pkg::FN_JK_R
        && $changed(cell_out));

endmodule
`default_nettype wire

// file: pkg/plc_pkg.sv
// package: constants, types and register map of the programmable logic cell back end
package plc_pkg;

    // ****************************************************************
    // register map
    // ****************************************************************
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam logic [3:0] OFS_CONTROL = 4'h0;
    localparam logic [3:0] OFS_G3_SELECT = 4'h1;
    localparam logic [3:0] OFS_POLARITY = 4'h2;

    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int BIT_ENABLE = 7;
    localparam int BIT_PIN_OE = 6;
    localparam int BIT_OUT_LEVEL = 5;
    localparam int BIT_RISE_EN = 4;
    localparam int BIT_FALL_EN = 3;
    localparam int BIT_FUNC_MSB = 2;
    localparam int BIT_FUNC_LSB = 0;
    localparam int BIT_OUT_INV = 7;
    localparam int BIT_GATE_INV_MSB = 3;

    // ****************************************************************
    // types
    // ****************************************************************
    typedef enum logic [2:0] {
        FN_AND_OR = 3'h0,
        FN_OR_XOR = 3'h1,
        FN_AND4 = 3'h2,
        FN_SR_LATCH = 3'h3,
        FN_D1_SR = 3'h4,
        FN_D2_R = 3'h5,
        FN_JK_R = 3'h6,
        FN_TLATCH_SR = 3'h7
    } plc_func_t;

    typedef struct packed {
        logic en;
        logic oe;
        logic rise;
        logic fall;
        plc_func_t func;
    } plc_ctl_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [3:0] addr;
        logic [7:0] wdata;
    } plc_bus_t;

    typedef logic [7:0] plc_sel_t;
    typedef logic [3:0] plc_gates_t;

    typedef struct packed {
        plc_ctl_t ctl;
        logic out_inv;
        logic [3:0] gate_inv;
        logic out;
        logic pulse;
        logic [7:0] rdata;
    } plc_core_st_t;

    typedef struct packed {
        logic q;
        logic clk_prev;
    } plc_func_st_t;

    // ****************************************************************
    // values after reset
    // ****************************************************************
    localparam plc_ctl_t CTL_RST = plc_ctl_t'(7'h00);
    localparam logic [3:0] GATE_INV_RST = 4'h0;
    localparam plc_core_st_t CORE_RST = plc_core_st_t'(22'h00_0000);
    localparam plc_func_st_t FUNC_RST = plc_func_st_t'(2'h0);

endpackage

// file: core/plc_gate.sv
// one data gate: AND of selected true or negated data, then polarity
`timescale 1ns/100ps
`default_nettype none
module plc_gate
(
    // gate select and polarity
    input wire plc_pkg::plc_sel_t sel,
    input wire logic invert,
    // selected data and result
    input wire logic [3:0] data,
    output logic gate_out
);

    logic [3:0] term;

    // ****************************************************************
    // per-input terms, an unselected input contributes one
    // ****************************************************************
    genvar i;
    generate
        for (i = 0; i < 4; i++)
        begin : g_term
            // odd bit gates true data, even bit gates negated data
            assign term[i] = (~sel[2*i+1] | data[i]) & (~sel[2*i] | ~data[i]);
        end
    endgenerate

    // and of all terms, empty selection gives constant one before polarity
    assign gate_out = (&term) ^ invert;

endmodule
`default_nettype wire

// file: core/plc_func.sv
// eight selectable logic functions of the cell
`timescale 1ns/100ps
`default_nettype none
module plc_func
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // control
    input wire logic enable,
    input wire plc_pkg::plc_func_t func,
    // gate outputs in, function result out
    input wire plc_pkg::plc_gates_t gates,
    output logic func_out
);

    plc_pkg::plc_func_st_t st_reg;
    plc_pkg::plc_func_st_t st_next;
    logic clk_rise;

    assign clk_rise = gates[0] & ~st_reg.clk_prev;

    // ****************************************************************
    // storage element update, held while the cell is off
    // ****************************************************************
    always_comb
    begin
        st_next = st_reg;
        if (enable)
        begin
            st_next.clk_prev = gates[0];
            case (func)
                plc_pkg::FN_SR_LATCH:
                begin
                    // set wins over reset
                    if (gates[0] | gates[1])
                        st_next.q = 1'b1;
                    else if (gates[2] | gates[3])
                        st_next.q = 1'b0;
                end
                plc_pkg::FN_D1_SR:
                begin
                    if (gates[2])
                        st_next.q = 1'b0;
                    else if (gates[3])
                        st_next.q = 1'b1;
                    else if (clk_rise)
                        st_next.q = gates[1];
                end
                plc_pkg::FN_D2_R:
                begin
                    if (gates[2])
                        st_next.q = 1'b0;
                    else if (clk_rise)
                        st_next.q = gates[1] & gates[3];
                end
                plc_pkg::FN_JK_R:
                begin
                    if (gates[2])
                        st_next.q = 1'b0;
                    else if (clk_rise)
                        st_next.q = (gates[1] & ~st_reg.q) | (~gates[3] & st_reg.q);
                end
                plc_pkg::FN_TLATCH_SR:
                begin
                    if (gates[2])
                        st_next.q = 1'b0;
                    else if (gates[3])
                        st_next.q = 1'b1;
                    else if (gates[0])
                        st_next.q = gates[1];
                end
                default:
                begin
                    st_next.q = st_reg.q;
                end
            endcase
        end
    end

    // result: combinational functions direct, others from storage
    always_comb
    begin
        case (func)
            plc_pkg::FN_AND_OR: func_out = (gates[0] & gates[1]) | (gates[2] & gates[3]);
            plc_pkg::FN_OR_XOR: func_out = (gates[0] | gates[1]) ^ (gates[2] | gates[3]);
            plc_pkg::FN_AND4: func_out = &gates;
            default: func_out = st_reg.q;
        endcase
    end

    // state register
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            st_reg <= plc_pkg::FUNC_RST;
        else
            st_reg <= st_next;
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rstn);

    chk_jk_toggle: assert property (
        enable && func == plc_pkg::FN_JK_R && clk_rise && !gates[2] && gates[1] && gates[3]
        |=> func_out != $past(func_out))
        else $error("jk flip-flop did not toggle");
    chk_sr_set: assert property (
        enable && func == plc_pkg::FN_SR_LATCH && (gates[0] || gates[1])
        ##1 func == plc_pkg::FN_SR_LATCH |-> func_out)
        else $error("s-r latch did not set");

endmodule
`default_nettype wire

// file: core/plc_unused_guard.sv
// spare file, holds no logic
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

// file: test/plc_periph_model.sv
// model of the peripherals and output pin at the far side of the cell
`timescale 1ns/100ps
`default_nettype none
module plc_periph_model
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // cell event pulse and pin drive
    input wire logic irq_set,
    input wire logic pin_out,
    input wire logic pin_oe_n,
    input wire logic flag_clr,
    // pin level and latched event flag
    output logic pin_wire,
    output logic event_flag
);
    logic last_drv;

    // last level that the cell drove onto the pin
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            last_drv <= 1'b0;
        else if (!pin_oe_n)
            last_drv <= pin_out;
    end

    // undriven pin shows the inverse of the last value, never a stale copy
    assign pin_wire = pin_oe_n ? ~last_drv : pin_out;

    // event flag: set by the cell pulse, cleared by software
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            event_flag <= 1'b0;
        else if (irq_set)
            event_flag <= 1'b1;
        else if (flag_clr)
            event_flag <= 1'b0;
    end
endmodule
`default_nettype wire

// file: test/testbench.sv
// self-checking bench of the logic cell back end
`timescale 1ns/100ps
`default_nettype none
module testbench;
    // ****************************************************************
    // signals
    // ****************************************************************
    logic core_clk;
    logic rstn;
    plc_pkg::plc_bus_t bus_req;
    logic [7:0] bus_rdata;
    logic [3:0] data_true;
    plc_pkg::plc_sel_t g1_sel;
    plc_pkg::plc_sel_t g2_sel;
    plc_pkg::plc_sel_t g4_sel;
    logic cell_out;
    logic input_mix_en;
    logic irq_set;
    logic pin_out;
    logic pin_oe_n;
    logic pin_wire;
    logic event_flag;
    logic flag_clr;
    int err_total;
    int n_tests;
    int n_irq;
    logic [7:0] rd_val;
    logic [7:0] sel3;
    logic [7:0] pol;
    logic [7:0] step;
    logic [3:0] gates;
    logic [2:0] func;
    logic oe;
    logic e;
    // sequence steps: function code, gate levels g4..g1, expected output
    logic [7:0] seq_tab [26] = '{8'h63, 8'h61, 8'h68, 8'h60, 8'h88, 8'h84, 8'h87, 8'h81,
        8'h88, 8'h91, 8'hA8, 8'hB4, 8'hB7, 8'hA7, 8'hA1, 8'hC8, 8'hD4, 8'hD7, 8'hD5,
        8'hD6, 8'hE8, 8'hE7, 8'hE5, 8'hE1, 8'hE2, 8'hF1};

    plc_core dut (.core_clk(core_clk), .rstn(rstn), .bus_req(bus_req), .bus_rdata(bus_rdata),
        .data_true(data_true), .g1_sel(g1_sel), .g2_sel(g2_sel), .g4_sel(g4_sel),
        .cell_out(cell_out), .input_mix_en(input_mix_en), .irq_set(irq_set),
        .pin_out(pin_out), .pin_oe_n(pin_oe_n));

    plc_periph_model far_side (.core_clk(core_clk), .rstn(rstn), .irq_set(irq_set),
        .pin_out(pin_out), .pin_oe_n(pin_oe_n), .flag_clr(flag_clr), .pin_wire(pin_wire),
        .event_flag(event_flag));

    // ****************************************************************
    // clock, event counter, watchdog
    // ****************************************************************
    initial
    begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    always @(posedge core_clk)
        if (irq_set === 1'b1)
            n_irq++;

    initial
    begin
        repeat (20000) @(posedge core_clk);
        err_total++;
        results();
    end

    // ****************************************************************
    // tasks and expectation functions
    // ****************************************************************
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic bus_wr(input logic [3:0] addr, input logic [7:0] data);
        @(posedge core_clk);
        bus_req <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
        @(posedge core_clk);
        bus_req <= '0;
    endtask

    task automatic bus_rd(input logic [3:0] addr);
        @(posedge core_clk);
        bus_req <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
        @(posedge core_clk);
        bus_req <= '0;
        #1 rd_val = bus_rdata;
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    // gate: AND of selected true or negated data, then polarity
    function automatic logic gexp(input logic [7:0] s, input logic inv, input logic [3:0] d);
        logic r;
        r = 1'b1;
        for (int k = 0; k < 4; k++)
            r &= (~s[2*k+1] | d[k]) & (~s[2*k] | ~d[k]);
        return r ^ inv;
    endfunction

    // combinational functions, gate 1 in bit 0
    function automatic logic fexp(input logic [2:0] f, input logic [3:0] g);
        case (f)
            3'h0: return (g[0] & g[1]) | (g[2] & g[3]);
            3'h1: return (g[0] | g[1]) ^ (g[2] | g[3]);
            default: return &g;
        endcase
    endfunction

    task automatic results();
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial
    begin
        rstn = 1'b0;
        bus_req = '0;
        data_true = 4'h0;
        g1_sel = 8'h00;
        g2_sel = 8'h00;
        g4_sel = 8'h00;
        flag_clr = 1'b0;
        err_total = 0;
        n_tests = 0;
        n_irq = 0;
        void'($urandom(32'h588d_aeb0));
        repeat (16) @(posedge core_clk);
        rstn <= 1'b1;
        idle(1);
        check("rst_out", {3'h0, cell_out, irq_set, pin_out, pin_oe_n, input_mix_en}, 8'h02);
        bus_rd(plc_pkg::OFS_CONTROL);
        check("rst_ctl", rd_val, 8'h00);
        bus_wr(4'hF, 8'hFF);
        bus_rd(4'hF);
        check("unmapped", rd_val, 8'h00);
        bus_rd(plc_pkg::OFS_CONTROL);
        check("ctl_kept", rd_val, 8'h00);
        bus_wr(plc_pkg::OFS_G3_SELECT, 8'h00);
        // random combinational traffic
        for (int i = 0; i < 48; i++)
        begin
            func = 3'($urandom_range(2));
            oe = 1'($urandom);
            sel3 = 8'($urandom & $urandom);
            pol = 8'($urandom) & 8'h8F;
            @(posedge core_clk);
            data_true <= 4'($urandom);
            g1_sel <= 8'($urandom & $urandom);
            g2_sel <= 8'($urandom & $urandom);
            g4_sel <= 8'($urandom & $urandom);
            bus_wr(plc_pkg::OFS_CONTROL, {1'b1, oe, 3'b000, func});
            bus_wr(plc_pkg::OFS_G3_SELECT, sel3);
            bus_wr(plc_pkg::OFS_POLARITY, pol);
            idle(3);
            gates = {gexp(g4_sel, pol[3], data_true), gexp(sel3, pol[2], data_true),
                gexp(g2_sel, pol[1], data_true), gexp(g1_sel, pol[0], data_true)};
            e = fexp(func, gates) ^ pol[7];
            check("cell_out", 8'(cell_out), 8'(e));
            check("pins", {5'h0, pin_oe_n, pin_out, input_mix_en}, {5'h0, ~oe, e, 1'b1});
            if (oe)
                check("pin_wire", 8'(pin_wire), 8'(e));
            bus_rd(plc_pkg::OFS_G3_SELECT);
            check("g3_select", rd_val, sel3);
        end
        // polarity flips as output edges, every enable combination
        @(posedge core_clk);
        g1_sel <= 8'h00;
        g2_sel <= 8'h00;
        g4_sel <= 8'h00;
        bus_wr(plc_pkg::OFS_G3_SELECT, 8'h00);
        for (int i = 0; i < 4; i++)
        begin
            bus_wr(plc_pkg::OFS_CONTROL, {3'b100, 1'(i), 1'(i >> 1), 3'h0});
            bus_wr(plc_pkg::OFS_POLARITY, 8'h00);
            idle(3);
            for (int j = 0; j < 2; j++)
            begin
                n_irq = 0;
                bus_wr(plc_pkg::OFS_POLARITY, j ? 8'h00 : 8'h80);
                idle(4);
                check("irq_count", 8'(n_irq), j ? 8'(i & 1) : 8'(i >> 1));
            end
        end
        check("event_flag", 8'(event_flag), 8'h01);
        @(posedge core_clk);
        flag_clr <= 1'b1;
        @(posedge core_clk);
        flag_clr <= 1'b0;
        // sequential modes driven by constant gates; status bit write ignored
        for (int i = 0; i < 26; i++)
        begin
            step = seq_tab[i];
            bus_wr(plc_pkg::OFS_CONTROL, {2'b10, ~step[0], 2'b00, step[7:5]});
            bus_wr(plc_pkg::OFS_POLARITY, {4'h0, ~step[4:1]});
            idle(3);
            bus_rd(plc_pkg::OFS_CONTROL);
            check("seq_ctl", rd_val, {2'b10, step[0], 2'b00, step[7:5]});
        end
        // disabled cell drives nothing
        bus_wr(plc_pkg::OFS_CONTROL, 8'h07);
        idle(3);
        check("disabled", {6'h0, cell_out, input_mix_en}, 8'h00);
        check("flag_clr", 8'(event_flag), 8'h00);
        // mid-run reset keeps gate 3 select
        bus_wr(plc_pkg::OFS_G3_SELECT, 8'hA5);
        rstn <= 1'b0;
        idle(2);
        rstn <= 1'b1;
        idle(1);
        bus_rd(plc_pkg::OFS_G3_SELECT);
        check("g3_kept", rd_val, 8'hA5);
        bus_rd(plc_pkg::OFS_CONTROL);
        check("ctl_reset", rd_val, 8'h00);
        results();
    end
endmodule
`default_nettype wire
